// ### design/setup_byte_store.sv
/*
 * Byte store for the per-key setups, one write port and a generated set
 * of registered read ports. Reset reloads the factory default byte.
 * Assumes addresses stay below DEPTH.
 */
`timescale 1ns/1ps
module setup_byte_store #(
    parameter int DEPTH = 24,
    parameter int AW = 5,
    parameter int NRD = 3
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic [NRD*AW-1:0] i_raddr,
    output logic [NRD*8-1:0] o_rdata
);
    import touch_setup_pkg::*;

    logic [7:0] mem_q [DEPTH];
    logic [NRD*8-1:0] rdata_d;

    always_comb begin
        for (int p = 0; p < NRD; p++) begin
            rdata_d[p*8 +: 8] = mem_q[i_raddr[p*AW +: AW]];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= SETUP_DEFAULT;
            end
            o_rdata <= '0;
        end else if (i_clk_en) begin
            if (i_we) begin
                mem_q[i_waddr] <= i_wdata;
            end
            o_rdata <= rdata_d;
        end
    end

endmodule : setup_byte_store

// ### design/touch_key_setup_detect.sv
/*
 * Setup register access, write protection, thresholds, drift compensation
 * and burst generation for a 24-key touch matrix.
 * Assumes a byte access port from the serial link and samples from the
 * acquisition front end; detect integrator lives outside.
 */
// Behaviour
// - Key setups and the rising drift byte are readable and writable, one byte per access; other setup addresses read zero.
// - Setups start protected; any read re-protects them.
// - Accepted setup bytes are stored and take effect at once.
// - Coded fields pass through fixed tables into operating values.
// - Touch candidate when signal lies more than threshold below reference.
// - Threshold levels follow the reference as it moves.
// - Signal more than threshold above reference recalibrates the reference.
// - Positive hysteresis is one eighth of the positive threshold.
// - Negative and positive thresholds share one per-key field.
// - Default threshold code 3 gives ten counts.
// - Drift moves reference toward signal only without detection.
// - Each drift step changes the reference by one count.
// - Drift halts while signal is beyond the negative threshold.
// - Falling rate per key, rising rate global.
// - Both drift defaults give one step per two seconds.
// - Each burst cycle pulses drive once with receive enabled.
// - Burst code 0 to 3 gives 16, 32, 48, 64 pulses; default 2.
`timescale 1ns/1ps
module touch_key_setup_detect #(
    parameter int TICK_CYCLES_P = touch_setup_pkg::TICK_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_acc_valid,
    input wire logic i_acc_write,
    input wire logic [7:0] i_acc_addr,
    input wire logic [7:0] i_acc_wdata,
    output logic [7:0] o_acc_rdata,
    output logic o_acc_rvalid,
    input wire logic i_sample_valid,
    input wire logic i_sample_cal,
    input wire logic [4:0] i_sample_key,
    input wire logic [11:0] i_sample_signal,
    input wire logic [touch_setup_pkg::NUM_KEYS-1:0] i_key_detect,
    input wire logic i_burst_start,
    input wire logic [4:0] i_burst_key,
    output logic o_x_drive,
    output logic o_y_enable,
    output logic o_burst_done,
    output logic o_burst_busy,
    output logic o_protected,
    output logic [touch_setup_pkg::NUM_KEYS-1:0] o_neg_cross,
    output logic [touch_setup_pkg::NUM_KEYS-1:0] o_pos_excursion
);
    import touch_setup_pkg::*;

    // ****************************************************************
    // Register access and write protection
    // ****************************************************************
    logic wp_q, wp_d;
    logic [2:0] rise_q, rise_d;
    logic rd_q, rd_d;
    logic sel_mem_q, sel_mem_d, sel_rise_q, sel_rise_d;
    logic [7:0] rdata_d;
    logic in_keys, in_setups, mem_we;
    logic [4:0] key_idx;
    logic [14:0] rd_addrs;
    logic [23:0] rd_data;

    function automatic logic [4:0] key_of(input logic [7:0] addr);
        key_of = 5'(addr - SETUP_BASE);
    endfunction : key_of

    assign key_idx = key_of(i_acc_addr);
    assign in_keys = (i_acc_addr >= SETUP_BASE) &&
                     (i_acc_addr < SETUP_BASE + 8'(NUM_KEYS));
    assign in_setups = (i_acc_addr >= SETUP_BASE) &&
                       (i_acc_addr <= SETUP_LAST);
    assign mem_we = i_acc_valid && i_acc_write && in_keys && !wp_q;

    always_comb begin
        wp_d = wp_q;
        rise_d = rise_q;
        if (i_acc_valid && !i_acc_write) begin
            wp_d = 1'b1;
        end else if (i_acc_valid && i_acc_addr == CMD_ADDR &&
                     i_acc_wdata == WR_ENABLE_CODE) begin
            wp_d = 1'b0;
        end
        if (i_acc_valid && i_acc_write && !wp_q &&
            i_acc_addr == RISE_DRIFT_ADDR) begin
            rise_d = i_acc_wdata[2:0];
        end
        rd_d = i_acc_valid && !i_acc_write;
        sel_mem_d = in_keys;
        sel_rise_d = in_setups && i_acc_addr == RISE_DRIFT_ADDR;
        rdata_d = READ_FILL;
        // Select is one stage old, in step with the registered store data
        if (sel_mem_q) begin
            rdata_d = rd_data[7:0];
        end else if (sel_rise_q) begin
            rdata_d = {5'h00, rise_q};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            wp_q <= 1'b1;
            rise_q <= RISE_DRIFT_DEFAULT;
            rd_q <= 1'b0;
            sel_mem_q <= 1'b0;
            sel_rise_q <= 1'b0;
            o_acc_rdata <= 8'h00;
            o_acc_rvalid <= 1'b0;
            o_protected <= 1'b1;
        end else if (i_clk_en) begin
            wp_q <= wp_d;
            rise_q <= rise_d;
            rd_q <= rd_d;
            sel_mem_q <= sel_mem_d;
            sel_rise_q <= sel_rise_d;
            o_acc_rdata <= rdata_d;
            o_acc_rvalid <= rd_q;
            o_protected <= wp_d;
        end
    end

    // Port 0 host reads, port 1 sampling, port 2 burst
    assign rd_addrs = {i_burst_key, i_sample_key, key_idx};

    setup_byte_store #(.DEPTH(NUM_KEYS), .AW(5), .NRD(3)) u_store (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_we(mem_we),
        .i_waddr(key_idx),
        .i_wdata(i_acc_wdata),
        .i_raddr(rd_addrs),
        .o_rdata(rd_data)
    );

    // ****************************************************************
    // Millisecond tick and per-key drift timers
    // ****************************************************************
    logic [15:0] tick_q, tick_d;
    logic tick;
    logic [ELAPSED_W-1:0] elapsed_q [NUM_KEYS];
    logic [ELAPSED_W-1:0] elapsed_d [NUM_KEYS];
    logic [11:0] ref_q [NUM_KEYS];
    logic [11:0] ref_d [NUM_KEYS];
    logic [NUM_KEYS-1:0] neg_d, pos_d;
    logic s_valid_q, s_cal_q;
    logic [4:0] s_key_q;
    logic [11:0] s_sig_q;
    logic [7:0] thr, hyst;
    logic [12:0] diff_up, diff_dn;
    logic above, below, near_pos, drift_ok, step_due;
    logic [11:0] cur_ref;
    logic [ELAPSED_W-1:0] due_ms;

    assign tick = (tick_q == 16'(TICK_CYCLES_P - 1));
    assign tick_d = tick ? 16'h0000 : tick_q + 16'h0001;
    assign cur_ref = ref_q[s_key_q];
    assign thr = thr_counts(rd_data[8+THR_MSB:8+THR_LSB]);
    assign hyst = thr >> HYST_SHIFT;
    // Thresholds are taken against the present reference each sample
    assign diff_up = {1'b0, s_sig_q} - {1'b0, cur_ref};
    assign diff_dn = {1'b0, cur_ref} - {1'b0, s_sig_q};
    assign above = s_sig_q > cur_ref && diff_up > {5'h00, thr};
    assign below = cur_ref > s_sig_q && diff_dn > {5'h00, thr};
    assign near_pos = s_sig_q > cur_ref &&
                      diff_up + {5'h00, hyst} > {5'h00, thr};
    assign drift_ok = !below && !i_key_detect[s_key_q];
    assign due_ms = (s_sig_q > cur_ref) ? drift_ms(rise_q) :
                    drift_ms(rd_data[8+DRIFT_MSB:8+DRIFT_LSB]);
    assign step_due = elapsed_q[s_key_q] >= due_ms;

    always_comb begin
        neg_d = o_neg_cross;
        pos_d = o_pos_excursion;
        for (int k = 0; k < NUM_KEYS; k++) begin
            ref_d[k] = ref_q[k];
            elapsed_d[k] = elapsed_q[k];
            if (tick && elapsed_q[k] != '1) begin
                elapsed_d[k] = elapsed_q[k] + 1'b1;
            end
        end
        if (s_valid_q) begin
            neg_d[s_key_q] = !s_cal_q && below;
            pos_d[s_key_q] = !s_cal_q && (above ||
                             (o_pos_excursion[s_key_q] && near_pos));
            if (s_cal_q || above) begin
                ref_d[s_key_q] = s_sig_q;
                elapsed_d[s_key_q] = '0;
            end else if (drift_ok && step_due && s_sig_q != cur_ref) begin
                ref_d[s_key_q] = (s_sig_q > cur_ref) ? cur_ref + 12'h001 :
                                 cur_ref - 12'h001;
                elapsed_d[s_key_q] = '0;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            tick_q <= 16'h0000;
            s_valid_q <= 1'b0;
            s_cal_q <= 1'b0;
            s_key_q <= 5'h00;
            s_sig_q <= 12'h000;
            o_neg_cross <= '0;
            o_pos_excursion <= '0;
            for (int k = 0; k < NUM_KEYS; k++) begin
                ref_q[k] <= 12'h000;
                elapsed_q[k] <= '0;
            end
        end else if (i_clk_en) begin
            tick_q <= tick_d;
            s_valid_q <= i_sample_valid;
            s_cal_q <= i_sample_cal;
            s_key_q <= i_sample_key;
            s_sig_q <= i_sample_signal;
            o_neg_cross <= neg_d;
            o_pos_excursion <= pos_d;
            for (int k = 0; k < NUM_KEYS; k++) begin
                ref_q[k] <= ref_d[k];
                elapsed_q[k] <= elapsed_d[k];
            end
        end
    end

    // ****************************************************************
    // Burst generator
    // ****************************************************************
    burst_state_t st_q, st_d;
    logic [6:0] left_q, left_d;
    logic done_d;

    always_comb begin
        st_d = st_q;
        left_d = left_q;
        done_d = 1'b0;
        case (st_q)
            B_IDLE: begin
                if (i_burst_start) begin
                    st_d = B_LOAD;
                end
            end
            B_LOAD: begin
                left_d = BURST_UNIT *
                         (7'(rd_data[16+BURST_MSB:16+BURST_LSB]) + 7'h01);
                st_d = B_DRIVE;
            end
            B_DRIVE: begin
                left_d = left_q - 7'h01;
                st_d = B_GAP;
            end
            B_GAP: begin
                if (left_q == 7'h00) begin
                    st_d = B_IDLE;
                    done_d = 1'b1;
                end else begin
                    st_d = B_DRIVE;
                end
            end
            default: st_d = B_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            st_q <= B_IDLE;
            left_q <= 7'h00;
            o_x_drive <= 1'b0;
            o_y_enable <= 1'b0;
            o_burst_done <= 1'b0;
            o_burst_busy <= 1'b0;
        end else if (i_clk_en) begin
            st_q <= st_d;
            left_q <= left_d;
            o_x_drive <= (st_d == B_DRIVE);
            o_y_enable <= (st_d == B_DRIVE);
            o_burst_done <= done_d;
            o_burst_busy <= (st_d != B_IDLE);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [6:0] pulses_q, want_q;
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pulses_q <= 7'h00;
            want_q <= 7'h00;
        end else if (i_clk_en) begin
            if (st_q == B_LOAD) begin
                pulses_q <= 7'h00;
                want_q <= left_d;
            end else if (o_x_drive) begin
                pulses_q <= pulses_q + 7'h01;
            end
        end
    end

    property p_read_protects;
        @(posedge i_core_clk) disable iff (i_sys_rst || !i_clk_en)
        (i_acc_valid && !i_acc_write) |=> wp_q;
    endproperty
    a_read_protects: assert property (p_read_protects)
        else $error("read did not re-protect setups");

    property p_protected_write;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_acc_valid && i_acc_write && in_keys && wp_q) |-> !mem_we;
    endproperty
    a_protected_write: assert property (p_protected_write)
        else $error("protected setup write was accepted");

    property p_read_latency;
        @(posedge i_core_clk) disable iff (i_sys_rst || !i_clk_en)
        (i_acc_valid && !i_acc_write) |=> ##1 o_acc_rvalid;
    endproperty
    a_read_latency: assert property (p_read_latency)
        else $error("read answer not two cycles after request");

    property p_neg_cross;
        @(posedge i_core_clk) disable iff (i_sys_rst || !i_clk_en)
        (s_valid_q && !s_cal_q && cur_ref > s_sig_q &&
         diff_dn > {5'h00, thr}) |=> o_neg_cross[$past(s_key_q)];
    endproperty
    a_neg_cross: assert property (p_neg_cross)
        else $error("negative crossing not flagged");

    property p_drift_halt;
        @(posedge i_core_clk) disable iff (i_sys_rst || !i_clk_en)
        (s_valid_q && !s_cal_q && !above &&
         (below || i_key_detect[s_key_q]))
        |=> ref_q[$past(s_key_q)] == $past(cur_ref);
    endproperty
    a_drift_halt: assert property (p_drift_halt)
        else $error("reference moved during detection");

    property p_recal;
        @(posedge i_core_clk) disable iff (i_sys_rst || !i_clk_en)
        (s_valid_q && above) |=> ref_q[$past(s_key_q)] == $past(s_sig_q);
    endproperty
    a_recal: assert property (p_recal)
        else $error("positive excursion did not recalibrate");

    property p_slew;
        @(posedge i_core_clk) disable iff (i_sys_rst || !i_clk_en)
        (s_valid_q && !s_cal_q && !above) |=>
        (ref_q[$past(s_key_q)] - $past(cur_ref) == 12'h001) ||
        ($past(cur_ref) - ref_q[$past(s_key_q)] == 12'h001) ||
        (ref_q[$past(s_key_q)] == $past(cur_ref));
    endproperty
    a_slew: assert property (p_slew)
        else $error("drift step larger than one count");

    property p_pulse_count;
        @(posedge i_core_clk) disable iff (i_sys_rst || !i_clk_en)
        o_burst_done |-> pulses_q == want_q;
    endproperty
    a_pulse_count: assert property (p_pulse_count)
        else $error("burst pulse count wrong");

    property p_drive_capture;
        @(posedge i_core_clk) disable iff (i_sys_rst || !i_clk_en)
        o_x_drive |-> o_y_enable ##1 !o_x_drive;
    endproperty
    a_drive_capture: assert property (p_drive_capture)
        else $error("drive pulse without capture or too long");

    c_burst: cover property (@(posedge i_core_clk) o_burst_done);
    c_setup_write: cover property (@(posedge i_core_clk) mem_we);
    c_touch: cover property (@(posedge i_core_clk) |o_neg_cross);

endmodule : touch_key_setup_detect

// ### design/touch_setup_pkg.sv
/*
 * Constants shared by the touch-key setup and detect block: setup map,
 * field layout, factory defaults, translation tables and timing.
 * Assumes a 25 MHz core clock and byte-wide setup accesses.
 */
package touch_setup_pkg;

    // ****************************************************************
    // Map and access codes
    // ****************************************************************
    localparam int NUM_KEYS = 24;
    localparam logic [7:0] CMD_ADDR = 8'h8C;
    localparam logic [7:0] SETUP_BASE = 8'h8D;
    localparam logic [7:0] SETUP_LAST = 8'hFA;
    localparam logic [7:0] RISE_DRIFT_ADDR = 8'hF9;
    localparam logic [7:0] WR_ENABLE_CODE = 8'hFE;

    // ****************************************************************
    // Per-key setup byte fields and defaults
    // ****************************************************************
    localparam int BURST_MSB = 7;
    localparam int BURST_LSB = 6;
    localparam int DRIFT_MSB = 5;
    localparam int DRIFT_LSB = 3;
    localparam int THR_MSB = 2;
    localparam int THR_LSB = 0;
    localparam logic [7:0] SETUP_DEFAULT = 8'hA3;
    localparam logic [2:0] RISE_DRIFT_DEFAULT = 3'h4;
    localparam logic [7:0] READ_FILL = 8'h00;

    // ****************************************************************
    // Translation constants
    // ****************************************************************
    localparam logic [7:0] THR_BASE_COUNTS = 8'h04;
    localparam logic [7:0] THR_STEP_COUNTS = 8'h02;
    localparam int HYST_SHIFT = 3;
    localparam logic [6:0] BURST_UNIT = 7'h10;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CORE_CLK_MHZ = 25;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES = TICK_TIME_US * CORE_CLK_MHZ;
    localparam int ELAPSED_W = 14;

    typedef enum logic [1:0] {
        B_IDLE = 2'b00,
        B_LOAD = 2'b01,
        B_DRIVE = 2'b11,
        B_GAP = 2'b10
    } burst_state_t;

    // Threshold code to counts
    function automatic logic [7:0] thr_counts(input logic [2:0] code);
        thr_counts = THR_BASE_COUNTS + THR_STEP_COUNTS * {5'h00, code};
    endfunction : thr_counts

    // Drift code to milliseconds per reference step
    function automatic logic [13:0] drift_ms(input logic [2:0] code);
        case (code)
            3'h0: drift_ms = 14'h0064;
            3'h1: drift_ms = 14'h00FA;
            3'h2: drift_ms = 14'h01F4;
            3'h3: drift_ms = 14'h03E8;
            3'h4: drift_ms = 14'h07D0;
            3'h5: drift_ms = 14'h0CE4;
            3'h6: drift_ms = 14'h1388;
            default: drift_ms = 14'h2710;
        endcase
    endfunction : drift_ms

endpackage : touch_setup_pkg

// ### sim/host_link_model.sv
/*
 * Host model for the byte access port: single writes, unlocked setup
 * writes and reads with a bounded wait for the answer.
 * Assumes the bench clock; requests change at the falling edge.
 */
`timescale 1ns/1ps
module host_link_model (
    input wire logic i_core_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output logic o_valid,
    output logic o_write,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    import touch_setup_pkg::*;

    initial begin
        o_valid = 1'b0;
        o_write = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end

    task automatic put(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(negedge i_core_clk);
        o_valid = 1'b1;
        o_write = w;
        o_addr = a;
        o_wdata = d;
        @(negedge i_core_clk);
        o_valid = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask : put

    // Enable code goes out just ahead of the setup byte
    task automatic wr_setup(input logic [7:0] a, input logic [7:0] d);
        put(1'b1, CMD_ADDR, WR_ENABLE_CODE);
        put(1'b1, a, d);
    endtask : wr_setup

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        bit got;
        d = 8'hXX;
        got = 1'b0;
        put(1'b0, a, 8'h00);
        for (int i = 0; i < 4 && !got; i++) begin
            @(negedge i_core_clk);
            if (i_rvalid === 1'b1) begin
                d = i_rdata;
                got = 1'b1;
            end
        end
    endtask : rd
endmodule : host_link_model

// ### sim/touch_key_setup_detect_test.sv
/*
 * Self-checking bench: setup map, protection, thresholds, drift, burst.
 * Assumes the host model on the access port and a 4-cycle tick.
 */
`timescale 1ns/1ps
module touch_key_setup_detect_test;
    import touch_setup_pkg::*;

    logic i_core_clk, i_sys_rst, i_clk_en;
    logic i_acc_valid, i_acc_write, o_acc_rvalid;
    logic [7:0] i_acc_addr, i_acc_wdata, o_acc_rdata, got;
    logic i_sample_valid, i_sample_cal, i_burst_start;
    logic [4:0] i_sample_key, i_burst_key;
    logic [11:0] i_sample_signal;
    logic [NUM_KEYS-1:0] i_key_detect, o_neg_cross, o_pos_excursion;
    logic o_x_drive, o_y_enable, o_burst_done, o_burst_busy, o_protected;
    int num_errors = 0;
    int check_count = 0;
    logic [23:0] rows [5] = '{
        {8'h8D, 8'h1B, 8'h1B}, {8'hA4, 8'hC7, 8'hC7},
        {8'hF9, 8'hFF, 8'h07}, {8'hA5, 8'h55, 8'h00},
        {8'h6B, 8'h12, 8'h00}};

    touch_key_setup_detect #(.TICK_CYCLES_P(4)) touch_key_setup_detect_inst (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
        .i_acc_valid(i_acc_valid), .i_acc_write(i_acc_write),
        .i_acc_addr(i_acc_addr), .i_acc_wdata(i_acc_wdata),
        .o_acc_rdata(o_acc_rdata), .o_acc_rvalid(o_acc_rvalid),
        .i_sample_valid(i_sample_valid), .i_sample_cal(i_sample_cal),
        .i_sample_key(i_sample_key), .i_sample_signal(i_sample_signal),
        .i_key_detect(i_key_detect), .i_burst_start(i_burst_start),
        .i_burst_key(i_burst_key), .o_x_drive(o_x_drive),
        .o_y_enable(o_y_enable), .o_burst_done(o_burst_done),
        .o_burst_busy(o_burst_busy), .o_protected(o_protected),
        .o_neg_cross(o_neg_cross), .o_pos_excursion(o_pos_excursion));

    host_link_model host_link_model_inst (
        .i_core_clk(i_core_clk), .i_rdata(o_acc_rdata),
        .i_rvalid(o_acc_rvalid), .o_valid(i_acc_valid),
        .o_write(i_acc_write), .o_addr(i_acc_addr), .o_wdata(i_acc_wdata));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic smp(input logic [4:0] k, input logic [11:0] s,
                       input logic c);
        @(negedge i_core_clk);
        i_sample_valid = 1'b1;
        i_sample_cal = c;
        i_sample_key = k;
        i_sample_signal = s;
        @(negedge i_core_clk);
        i_sample_valid = 1'b0;
        i_sample_signal = ~s;
        repeat (2) @(negedge i_core_clk);
    endtask : smp

    task automatic burst(input logic [4:0] k, output logic [7:0] nx,
                         output logic [7:0] ny);
        nx = 8'h00;
        ny = 8'h00;
        @(negedge i_core_clk);
        i_burst_start = 1'b1;
        i_burst_key = k;
        @(negedge i_core_clk);
        i_burst_start = 1'b0;
        for (int w = 0; w < 300 && o_burst_done !== 1'b1; w++) begin
            nx += {7'h00, o_x_drive === 1'b1};
            ny += {7'h00, o_y_enable === 1'b1};
            @(negedge i_core_clk);
        end
    endtask : burst

    task automatic do_reset();
        i_sys_rst = 1'b1;
        repeat (3) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
    endtask : do_reset

    initial begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end

    initial begin
        repeat (40000) @(posedge i_core_clk);
        num_errors++;
        conclude();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        logic [7:0] nx, ny;
        i_clk_en = 1'b1;
        i_sample_valid = 1'b0;
        i_sample_cal = 1'b0;
        i_sample_key = 5'h00;
        i_sample_signal = 12'h000;
        i_key_detect = '0;
        i_burst_start = 1'b0;
        i_burst_key = 5'h00;
        do_reset();
        check({7'h00, o_protected}, 8'h01);
        for (int k = 0; k < NUM_KEYS; k++) begin
            host_link_model_inst.rd(SETUP_BASE + 8'(k), got);
            check(got, 8'hA3);
        end
        host_link_model_inst.rd(8'hF9, got);
        check(got, 8'h04);
        foreach (rows[i]) begin
            host_link_model_inst.wr_setup(rows[i][23:16], rows[i][15:8]);
            host_link_model_inst.rd(rows[i][23:16], got);
            check(got, rows[i][7:0]);
        end
        // Frozen clock enable: a read must not re-protect
        host_link_model_inst.put(1'b1, CMD_ADDR, WR_ENABLE_CODE);
        i_clk_en = 1'b0;
        host_link_model_inst.rd(8'h8E, got);
        check({7'h00, o_protected}, 8'h00);
        i_clk_en = 1'b1;
        host_link_model_inst.wr_setup(8'h8E, 8'h00);
        check({7'h00, o_protected}, 8'h00);
        host_link_model_inst.rd(8'h8E, got);
        check({7'h00, o_protected}, 8'h01);
        host_link_model_inst.put(1'b1, 8'h8E, 8'hFF);
        host_link_model_inst.rd(8'h8E, got);
        check(got, 8'h00);
        do_reset();
        smp(5'd2, 12'h3E8, 1'b1);
        smp(5'd2, 12'h3DE, 1'b0);
        check({7'h00, o_neg_cross[2]}, 8'h00);
        smp(5'd2, 12'h3DD, 1'b0);
        check({7'h00, o_neg_cross[2]}, 8'h01);
        host_link_model_inst.wr_setup(8'h8F, 8'hA0);
        smp(5'd2, 12'h3E3, 1'b0);
        check({7'h00, o_neg_cross[2]}, 8'h01);
        smp(5'd2, 12'h3ED, 1'b0);
        check({7'h00, o_pos_excursion[2]}, 8'h01);
        smp(5'd2, 12'h3E8, 1'b0);
        check({7'h00, o_neg_cross[2]}, 8'h01);
        host_link_model_inst.wr_setup(8'h8F, 8'hA7);
        smp(5'd2, 12'h3E8, 1'b1);
        smp(5'd2, 12'h3FB, 1'b0);
        smp(5'd2, 12'h40C, 1'b0);
        check({7'h00, o_pos_excursion[2]}, 8'h01);
        smp(5'd2, 12'h40B, 1'b0);
        check({7'h00, o_pos_excursion[2]}, 8'h00);
        // Rising drift fastest, falling left slow
        host_link_model_inst.wr_setup(8'hF9, 8'h00);
        i_key_detect[3] = 1'b1;
        smp(5'd3, 12'h3E8, 1'b1);
        repeat (500) @(negedge i_core_clk);
        smp(5'd3, 12'h3ED, 1'b0);
        smp(5'd3, 12'h3DE, 1'b0);
        check({7'h00, o_neg_cross[3]}, 8'h00);
        i_key_detect[3] = 1'b0;
        smp(5'd3, 12'h3E8, 1'b1);
        repeat (500) @(negedge i_core_clk);
        smp(5'd3, 12'h3ED, 1'b0);
        smp(5'd3, 12'h3DF, 1'b0);
        check({7'h00, o_neg_cross[3]}, 8'h00);
        smp(5'd3, 12'h3DE, 1'b0);
        check({7'h00, o_neg_cross[3]}, 8'h01);
        smp(5'd3, 12'h3E8, 1'b1);
        repeat (500) @(negedge i_core_clk);
        smp(5'd3, 12'h3E3, 1'b0);
        smp(5'd3, 12'h3F2, 1'b0);
        check({7'h00, o_pos_excursion[3]}, 8'h00);
        for (int c = 0; c < 4; c++) begin
            host_link_model_inst.wr_setup(8'h92, {2'(c), 6'h1B});
            burst(5'd5, nx, ny);
            check(nx, 8'(16 * (c + 1)));
            check(ny, 8'(16 * (c + 1)));
            check({7'h00, o_burst_busy}, 8'h00);
        end
        conclude();
    end
endmodule : touch_key_setup_detect_test
